// File: rtl/select_sync_serial_unit.sv
// select_sync_serial_unit: clocked serial unit with chip select, AHB-Lite registers
// assumes: pins are synchronous to sys_clk; one AHB-Lite master, zero wait states
`timescale 1ns/1ps
module select_sync_serial_unit #(
    parameter int WORD_BITS = 8
) (
    input wire logic sys_clk, // system clock f1
    input wire logic rst, // synchronous reset, active high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // ready except during reset
    output logic hresp, // always OKAY
    output logic [31:0] hrdata, // read data
    input wire logic bus_function_switch, // high selects the other bus function
    input wire logic serial_clock_pin_in, // clock pin level
    output logic serial_clock_pin_out, // clock pin drive
    output logic serial_clock_pin_oe, // clock pin enable
    input wire logic data_pin_in, // serial data in
    output logic data_pin_out, // serial data out
    output logic data_pin_out_oe, // data out enable
    input wire logic chip_select_pin, // chip select, low active level
    output logic irq // combined interrupt request
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    // eight bits only
    if (WORD_BITS != 8)
    begin : g_bad_width
        $error("word width must be 8");
    end

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    sync_serial_pkg::bus_req_type req_q;
    logic [7:0] ctrl_high_q;
    logic ctrl_soft_reset_q;
    logic sol_q;
    logic [7:0] mode_q;
    logic [7:0] enable_q;
    logic four_wire_q;
    logic [7:0] tx_data_q;
    logic tx_pending_q;
    logic [7:0] rx_data_q;
    sync_serial_pkg::flags_type flags_q;
    sync_serial_pkg::flags_type seen_q;
    sync_serial_pkg::eng_state_type state_q;
    logic [7:0] shift_reg_q;
    logic [7:0] rx_shift_q;
    logic [4:0] edge_cnt_q;
    logic [7:0] div_cnt_q;
    logic sclk_q;
    logic sclk_in_q;
    logic cs_q;
    logic eng_rst;
    logic unit_on;
    logic master;
    logic tx_en;
    logic rx_en;
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic [7:0] half;
    logic bus_valid;
    logic wr;
    logic rd_status;
    logic rd_rx;
    logic wr_tx;
    logic [7:0] wdata;
    logic can_start;
    logic start;
    logic conflict_set;
    logic edge_ev;
    logic sample_ev;
    logic change_ev;
    logic done;
    logic [7:0] rx_next;
    logic load_tx;
    logic [7:0] read_mux;

    // ------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------
    // only unit modes with both i2c selects low
    assign unit_on = !bus_function_switch && !ctrl_high_q[sync_serial_pkg::CH_IIC_BIT];
    assign master = ctrl_high_q[sync_serial_pkg::CH_MASTER_BIT];
    assign tx_en = enable_q[sync_serial_pkg::EN_TE_BIT];
    assign rx_en = enable_q[sync_serial_pkg::EN_RE_BIT];
    assign cpol = mode_q[sync_serial_pkg::MD_CPOL_BIT];
    assign cpha = mode_q[sync_serial_pkg::MD_CPHA_BIT];
    assign lsb_first = mode_q[sync_serial_pkg::MD_ORDER_BIT];
    // engine held while soft reset bit is one
    assign eng_rst = rst || ctrl_soft_reset_q;
    // code 0 is f1/256 down to code 6 at f1/4; code 7 falls back to slowest
    assign half = (ctrl_high_q[2:0] > sync_serial_pkg::CKS_MAX) ?
        8'(sync_serial_pkg::HALF_MIN << sync_serial_pkg::CKS_MAX) :
        8'(sync_serial_pkg::HALF_MIN << (sync_serial_pkg::CKS_MAX - ctrl_high_q[2:0]));

    // ------------------------------------------------------------
    // bus decode: address phase taken, data phase next cycle
    // ------------------------------------------------------------
    assign bus_valid = hsel && htrans[1] && hready && (haddr[31:10] == 22'h0)
        && (haddr[1:0] == 2'b00);
    assign rd_status = bus_valid && !hwrite && (haddr[9:2] == sync_serial_pkg::IDX_STATUS);
    assign rd_rx = bus_valid && !hwrite && (haddr[9:2] == sync_serial_pkg::IDX_RX_DATA);
    assign wr = req_q.valid && req_q.write;
    assign wdata = hwdata[7:0];
    assign wr_tx = wr && (req_q.idx == sync_serial_pkg::IDX_TX_DATA);

    // read value chosen in the address phase, held in hrdata for the data phase
    always_comb
    begin
        read_mux = 8'h00;
        case (haddr[9:2])
            sync_serial_pkg::IDX_CTRL_HIGH: read_mux = ctrl_high_q;
            // idle level bit returns the actual output level
            sync_serial_pkg::IDX_CTRL_LOW: read_mux = sync_serial_pkg::CTRL_LOW_ONES
                | ({7'h00, data_pin_out} << sync_serial_pkg::CL_SOL_BIT)
                | ({7'h00, ctrl_soft_reset_q} << sync_serial_pkg::CL_CTRL_SOFT_RESET_BIT);
            sync_serial_pkg::IDX_MODE: read_mux = mode_q;
            sync_serial_pkg::IDX_ENABLE: read_mux = enable_q;
            sync_serial_pkg::IDX_STATUS: read_mux = {flags_q.tx_empty, flags_q.tx_done,
                flags_q.rx_full, 2'b00, flags_q.overrun, 1'b0, flags_q.conflict};
            sync_serial_pkg::IDX_MODE_TWO: read_mux = {7'h00, four_wire_q};
            sync_serial_pkg::IDX_TX_DATA: read_mux = tx_data_q;
            sync_serial_pkg::IDX_RX_DATA: read_mux = rx_data_q;
            default: read_mux = 8'h00;
        endcase
    end

    // bus response flops; unmapped reads return zero with OKAY
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            req_q <= '0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            req_q.valid <= bus_valid;
            req_q.write <= hwrite;
            req_q.idx <= haddr[9:2];
            // unmapped or misaligned reads give zero, never stale data
            if (hsel && htrans[1] && hready && !hwrite)
            begin
                hrdata <= bus_valid ? {24'h000000, read_mux} : 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // software written registers
    // ------------------------------------------------------------
    // one window of eight registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_high_q <= sync_serial_pkg::CTRL_HIGH_RST;
            mode_q <= sync_serial_pkg::MODE_RST;
            enable_q <= sync_serial_pkg::ENABLE_RST;
            four_wire_q <= sync_serial_pkg::MODE_TWO_RST[sync_serial_pkg::M2_FOUR_BIT];
        end
        else
        begin
            if (wr && req_q.idx == sync_serial_pkg::IDX_CTRL_HIGH)
            begin
                ctrl_high_q <= wdata;
            end
            if (conflict_set)
            begin
                ctrl_high_q[sync_serial_pkg::CH_MASTER_BIT] <= 1'b0;
            end
            if (wr && req_q.idx == sync_serial_pkg::IDX_MODE)
            begin
                mode_q <= wdata;
            end
            if (wr && req_q.idx == sync_serial_pkg::IDX_ENABLE)
            begin
                enable_q <= wdata;
            end
            if (wr && req_q.idx == sync_serial_pkg::IDX_MODE_TWO)
            begin
                four_wire_q <= wdata[sync_serial_pkg::M2_FOUR_BIT];
            end
        end
    end

    // control low: soft reset and protected idle level
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_soft_reset_q <= sync_serial_pkg::CTRL_LOW_RST[sync_serial_pkg::CL_CTRL_SOFT_RESET_BIT];
            sol_q <= sync_serial_pkg::CTRL_LOW_RST[sync_serial_pkg::CL_SOL_BIT];
        end
        else if (wr && req_q.idx == sync_serial_pkg::IDX_CTRL_LOW)
        begin
            ctrl_soft_reset_q <= wdata[sync_serial_pkg::CL_CTRL_SOFT_RESET_BIT];
            // idle level only with protect written zero
            if (!wdata[sync_serial_pkg::CL_IDLE_LEVEL_PROTECT_BIT])
            begin
                sol_q <= wdata[sync_serial_pkg::CL_SOL_BIT];
            end
        end
    end

    // transmit buffer; pending means not yet moved to the shift register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_data_q <= 8'h00;
            tx_pending_q <= 1'b0;
        end
        else if (wr_tx)
        begin
            tx_data_q <= wdata;
            tx_pending_q <= 1'b1;
        end
        else if (load_tx || ctrl_soft_reset_q)
        begin
            tx_pending_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status flags: hardware set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_q <= sync_serial_pkg::STATUS_RST[4:0];
            seen_q <= '0;
            rx_data_q <= 8'h00;
        end
        else
        begin
            if (rd_status)
            begin
                seen_q <= flags_q;
            end
            // zero written after one was read
            if (wr && req_q.idx == sync_serial_pkg::IDX_STATUS)
            begin
                seen_q <= '0;
                if (!wdata[sync_serial_pkg::ST_TX_EMPTY_FLAG_BIT] && seen_q.tx_empty)
                    flags_q.tx_empty <= 1'b0;
                if (!wdata[sync_serial_pkg::ST_TX_DONE_FLAG_BIT] && seen_q.tx_done)
                    flags_q.tx_done <= 1'b0;
                if (!wdata[sync_serial_pkg::ST_RX_FULL_FLAG_BIT] && seen_q.rx_full)
                    flags_q.rx_full <= 1'b0;
                if (!wdata[sync_serial_pkg::ST_OVERRUN_FLAG_BIT] && seen_q.overrun)
                    flags_q.overrun <= 1'b0;
                if (!wdata[sync_serial_pkg::ST_CE_BIT] && seen_q.conflict)
                    flags_q.conflict <= 1'b0;
            end
            // transmit write clears empty and end
            if (wr_tx)
            begin
                flags_q.tx_empty <= 1'b0;
                flags_q.tx_done <= 1'b0;
            end
            if (rd_rx)
            begin
                flags_q.rx_full <= 1'b0;
            end
            if (load_tx)
            begin
                flags_q.tx_empty <= 1'b1;
            end
            // end of word with nothing waiting
            if (done && tx_en && !tx_pending_q && !wr_tx)
            begin
                flags_q.tx_done <= 1'b1;
            end
            if (done && rx_en)
            begin
                // receive full still set means overrun
                if (flags_q.rx_full && !rd_rx)
                begin
                    flags_q.overrun <= 1'b1;
                end
                else
                begin
                    // word lands in receive data register
                    rx_data_q <= rx_next;
                    flags_q.rx_full <= 1'b1;
                end
            end
            if (conflict_set)
            begin
                flags_q.conflict <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    // nothing starts while overrun stands
    assign can_start = unit_on && !flags_q.overrun && (tx_en || rx_en)
        && (!tx_en || tx_pending_q) && (!rx_en || tx_en || !flags_q.rx_full);
    // master finds chip select low at start
    assign conflict_set = (state_q == sync_serial_pkg::ST_IDLE && can_start && master
        && four_wire_q && !chip_select_pin)
        // slave sees chip select rise mid-transfer
        || (state_q == sync_serial_pkg::ST_RUN && !master && four_wire_q
        && !cs_q && chip_select_pin);
    assign start = state_q == sync_serial_pkg::ST_IDLE && can_start && !conflict_set
        && (master || !four_wire_q || !chip_select_pin);
    assign load_tx = start && tx_en;
    // master edges from the divider; slave edges from the pin
    assign edge_ev = (state_q == sync_serial_pkg::ST_RUN) && (master ?
        (div_cnt_q == half - 8'h01) : (sclk_in_q != serial_clock_pin_in));
    assign sample_ev = edge_ev && (edge_cnt_q[0] == cpha);
    assign change_ev = edge_ev && (edge_cnt_q[0] != cpha) && (edge_cnt_q != 5'h00);
    assign done = edge_ev && (edge_cnt_q == sync_serial_pkg::LAST_EDGE);
    // lsb first fills from the top, msb first from the bottom
    assign rx_next = !sample_ev ? rx_shift_q :
        (lsb_first ? {data_pin_in, rx_shift_q[7:1]} : {rx_shift_q[6:0], data_pin_in});

    // engine state and counters, cleared by soft reset too
    always_ff @(posedge sys_clk)
    begin
        if (eng_rst)
        begin
            state_q <= sync_serial_pkg::ST_IDLE;
            edge_cnt_q <= 5'h00;
            div_cnt_q <= 8'h00;
            sclk_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                sync_serial_pkg::ST_IDLE:
                begin
                    sclk_q <= cpol;
                    edge_cnt_q <= 5'h00;
                    div_cnt_q <= 8'h00;
                    if (start)
                    begin
                        state_q <= sync_serial_pkg::ST_RUN;
                    end
                end
                sync_serial_pkg::ST_RUN:
                begin
                    div_cnt_q <= edge_ev ? 8'h00 : div_cnt_q + 8'h01;
                    if (edge_ev)
                    begin
                        sclk_q <= !sclk_q;
                        edge_cnt_q <= edge_cnt_q + 5'h01;
                    end
                    if (done || conflict_set || !unit_on)
                    begin
                        state_q <= sync_serial_pkg::ST_IDLE;
                    end
                end
                default: state_q <= sync_serial_pkg::ST_IDLE;
            endcase
        end
    end

    // shift register cleared by soft reset
    always_ff @(posedge sys_clk)
    begin
        if (eng_rst)
        begin
            shift_reg_q <= 8'h00;
            rx_shift_q <= 8'h00;
        end
        else
        begin
            rx_shift_q <= rx_next;
            if (load_tx)
            begin
                shift_reg_q <= tx_data_q;
            end
            else if (change_ev)
            begin
                shift_reg_q <= lsb_first ? {1'b0, shift_reg_q[7:1]} : {shift_reg_q[6:0], 1'b0};
            end
        end
    end

    // pin history for slave clock edges and chip select rise; pins are synchronous
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sclk_in_q <= 1'b0;
            cs_q <= 1'b1;
        end
        else
        begin
            sclk_in_q <= serial_clock_pin_in;
            cs_q <= chip_select_pin;
        end
    end

    // ------------------------------------------------------------
    // pins and interrupt, all from flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            data_pin_out <= 1'b1;
            data_pin_out_oe <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            serial_clock_pin_out <= sclk_q;
            // clock released once master select drops
            serial_clock_pin_oe <= unit_on && master && !conflict_set;
            data_pin_out_oe <= unit_on && tx_en;
            // idle level holds after a word
            if (state_q == sync_serial_pkg::ST_RUN && tx_en)
                data_pin_out <= lsb_first ? shift_reg_q[0] : shift_reg_q[7];
            else
                data_pin_out <= sol_q;
            // enable and flag; five sources ORed
            irq <= (enable_q[sync_serial_pkg::EN_TIE_BIT] && flags_q.tx_empty)
                || (enable_q[sync_serial_pkg::EN_TX_DONE_IRQ_EN_BIT] && flags_q.tx_done)
                || (enable_q[sync_serial_pkg::EN_RIE_BIT] && flags_q.rx_full)
                || (enable_q[sync_serial_pkg::EN_RIE_BIT] && flags_q.overrun)
                || (enable_q[sync_serial_pkg::EN_CONFLICT_IRQ_EN_BIT] && flags_q.conflict);
        end
    end
endmodule

// File: rtl/sync_serial_pkg.sv
// sync_serial_pkg: register indices, field positions, reset values, types
// assumes: registers sit on a 32-bit AHB-Lite word each, byte address = 4 x index
package sync_serial_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_HIGH = 8'hB8;
    localparam logic [7:0] IDX_CTRL_LOW = 8'hB9;
    localparam logic [7:0] IDX_MODE = 8'hBA;
    localparam logic [7:0] IDX_ENABLE = 8'hBB;
    localparam logic [7:0] IDX_STATUS = 8'hBC;
    localparam logic [7:0] IDX_MODE_TWO = 8'hBD;
    localparam logic [7:0] IDX_TX_DATA = 8'hBE;
    localparam logic [7:0] IDX_RX_DATA = 8'hBF;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CH_IIC_BIT = 7;
    localparam int CH_MASTER_BIT = 6;
    localparam int CH_CKS_LSB = 0;
    localparam int CL_CTRL_SOFT_RESET_BIT = 1;
    localparam int CL_IDLE_LEVEL_PROTECT_BIT = 4;
    localparam int CL_SOL_BIT = 5;
    localparam int MD_ORDER_BIT = 7;
    localparam int MD_CPOL_BIT = 1;
    localparam int MD_CPHA_BIT = 0;
    localparam int M2_FOUR_BIT = 0;
    localparam int EN_CONFLICT_IRQ_EN_BIT = 0;
    localparam int EN_RE_BIT = 3;
    localparam int EN_TE_BIT = 4;
    localparam int EN_RIE_BIT = 5;
    localparam int EN_TX_DONE_IRQ_EN_BIT = 6;
    localparam int EN_TIE_BIT = 7;
    localparam int ST_CE_BIT = 0;
    localparam int ST_OVERRUN_FLAG_BIT = 2;
    localparam int ST_RX_FULL_FLAG_BIT = 5;
    localparam int ST_TX_DONE_FLAG_BIT = 6;
    localparam int ST_TX_EMPTY_FLAG_BIT = 7;
    // ------------------------------------------------------------
    // reset values and constant read bits
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_HIGH_RST = 8'h00;
    localparam logic [7:0] CTRL_LOW_RST = 8'h7D;
    localparam logic [7:0] CTRL_LOW_ONES = 8'h5D;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MODE_TWO_RST = 8'h00;
    // ------------------------------------------------------------
    // timing: half period of f1/4 in sys_clk cycles, fastest code
    // ------------------------------------------------------------
    localparam logic [7:0] HALF_MIN = 8'h02;
    localparam logic [2:0] CKS_MAX = 3'h6;
    localparam logic [4:0] LAST_EDGE = 5'h0F;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic tx_empty;
        logic tx_done;
        logic rx_full;
        logic overrun;
        logic conflict;
    } flags_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } bus_req_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } eng_state_type;
endpackage

// File: testbench/serial_peer.sv
// serial_peer: external slave answering the unit's master transfers
// assumes: clock idles low, leading edge samples
`timescale 1ns/1ps
module serial_peer (
    input wire logic sys_clk, // system clock
    input wire logic sck, // link clock
    input wire logic din, // data from unit
    input wire logic [7:0] reply, // word to send
    output logic dout, // data to unit
    output logic [7:0] got // word received
);
    logic sck_q = 1'b0;
    logic [2:0] idx = 3'h0;
    initial got = 8'h00;
    // capture on rise, change on fall
    always @(posedge sys_clk)
    begin
        sck_q <= sck;
        if (sck && !sck_q)
            got <= {got[6:0], din};
        if (!sck && sck_q)
            idx <= idx + 3'h1;
    end
    // eight bits, msb of reply first
    assign dout = reply[3'h7 - idx];
endmodule

// File: testbench/sunit_sva.sv
// sunit_sva: port assertions for the serial unit
// assumes: bound to the unit top, one clock domain
`timescale 1ns/1ps
module sunit_sva (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic hreadyout, // ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire logic bus_function_switch, // unit off
    input wire logic serial_clock_pin_out, // clock out
    input wire logic serial_clock_pin_oe, // clock enable
    input wire logic data_pin_out, // data out
    input wire logic data_pin_out_oe, // data enable
    input wire logic irq // request
);
    // read address phase taken by the unit
    logic rd;
    assign rd = hsel && htrans[1] && !hwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_ready; !$past(rst) |-> hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("not ready");
    property p_rst; $fell(rst) |-> !irq && !serial_clock_pin_oe && data_pin_out; endproperty
    a_rst: assert property (p_rst) else $error("bad reset outputs");
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_hold; !rd |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; rd && haddr[31:10] != 22'h0 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    // fastest clock is f1/4, so no level lasts under two cycles
    property p_half; serial_clock_pin_oe && $changed(serial_clock_pin_out)
        |=> $stable(serial_clock_pin_out); endproperty
    a_half: assert property (p_half) else $error("clock too fast");
    property p_off; bus_function_switch [*2] |-> !serial_clock_pin_oe && !data_pin_out_oe; endproperty
    a_off: assert property (p_off) else $error("unit drives while off");
endmodule

// File: testbench/tb_top.sv
// tb_top: register and transfer scenarios, peer slave on the pins
// assumes: unit is master in plain mode, clock code 4
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic bfs = 1'b0;
    logic cs = 1'b1;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rv;
    logic hreadyout, sck, sck_oe, miso, mosi, irq;
    logic [7:0] got;
    int failures = 0;
    int cmp_count = 0;
    always #50 sys_clk = ~sys_clk;
    select_sync_serial_unit u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .bus_function_switch(bfs),
        .serial_clock_pin_in(sck & sck_oe), .serial_clock_pin_out(sck),
        .serial_clock_pin_oe(sck_oe), .data_pin_in(miso), .data_pin_out(mosi),
        .data_pin_out_oe(), .chip_select_pin(cs), .irq(irq));
    // released clock line is pulled low
    serial_peer u_peer (.sys_clk(sys_clk), .sck(sck & sck_oe), .din(mosi), .reply(8'h0F),
        .dout(miso), .got(got));
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [31:0] a, input string n, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rv[7:0]);
    endtask
    // poll status until one flag shows, bounded
    task automatic poll(input int b);
        rv = 32'h0;
        for (int i = 0; i < 300 && rv[b] !== 1'b1; i++)
            bus(1'b0, 32'h2F0, 32'h0);
    endtask
    task automatic t_regs();
        rd(32'h2E4, "ctrl low", 8'h7D);
        rd(32'h400, "unmapped", 8'h00);
        rd(32'h2EC, "enable", 8'h00);
        rd(32'h2F0, "status", 8'h00);
        bus(1'b1, 32'h2E4, 32'h10);
        rd(32'h2E4, "protected", 8'h7D);
        bus(1'b1, 32'h2E4, 32'h00);
        rd(32'h2E4, "idle low", 8'h5D);
        bus(1'b1, 32'h2E4, 32'h20);
        rd(32'h2E4, "idle high", 8'h7D);
    endtask
    task automatic t_msb();
        bus(1'b1, 32'h2E0, 32'h44);
        bus(1'b1, 32'h2EC, 32'h38);
        // unit switched off while armed as master: pins must be released
        bfs <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bfs <= 1'b0;
        bus(1'b1, 32'h2F8, 32'hA6);
        poll(5);
        rd(32'h2F0, "status", 8'hE0);
        chk("irq", 8'h01, {7'h0, irq});
        chk("peer msb", 8'hA6, got);
        rd(32'h2FC, "rx data", 8'h0F);
        rd(32'h2F0, "rx read", 8'hC0);
    endtask
    task automatic t_lsb();
        bus(1'b1, 32'h2E8, 32'h80);
        bus(1'b1, 32'h2F8, 32'h01);
        poll(5);
        chk("peer lsb", 8'h80, got);
        bus(1'b1, 32'h2F8, 32'h01);
        poll(2);
        rd(32'h2F0, "overrun", 8'hE4);
        bus(1'b1, 32'h2F8, 32'h55);
        repeat (200) @(posedge sys_clk);
        chk("halted", 8'h80, got);
        bus(1'b1, 32'h2EC, 32'h18);
        rd(32'h2F0, "tx write", 8'h24);
        chk("irq off", 8'h00, {7'h0, irq});
        bus(1'b1, 32'h2F0, 32'hFF);
        rd(32'h2F0, "write one", 8'h24);
        rd(32'h2FC, "rx data", 8'hF0);
        rd(32'h2F0, "status", 8'h04);
        bus(1'b1, 32'h2F0, 32'h00);
        poll(5);
        chk("resumed", 8'hAA, got);
        rd(32'h2F0, "cleared", 8'hE0);
    endtask
    // four-wire conflicts: master start with select low, then slave sees select rise
    task automatic t_cs();
        bus(1'b1, 32'h2F4, 32'h01);
        cs <= 1'b0;
        bus(1'b1, 32'h2F8, 32'h33);
        rd(32'h2E0, "slave again", 8'h04);
        rd(32'h2F0, "master conflict", 8'hA1);
        bus(1'b1, 32'h2F0, 32'h00);
        cs <= 1'b1;
        rd(32'h2F0, "slave conflict", 8'h01);
    endtask
    task automatic end_sim();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_msb();
        t_lsb();
        t_cs();
        end_sim();
    end
    // watchdog: far beyond the several hundred cycles the scenarios need
    initial
    begin
        #2000000;
        failures++;
        end_sim();
    end
endmodule
bind select_sync_serial_unit sunit_sva u_sva (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .bus_function_switch(bus_function_switch),
    .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
    .data_pin_out(data_pin_out), .data_pin_out_oe(data_pin_out_oe), .irq(irq));
